// ---- hdl/cit_pkg.sv ----
// shared constants and types for the core instruction timing block
package cit_pkg;
	localparam int CYC_W = 5;
	localparam int LEN_W = 2;
	localparam int PC_W = 16;
	localparam int ALE_W = 2;
	localparam int PULSE_W = 3;
	localparam logic [PC_W-1:0] RESET_PC = 16'h0000;
	localparam logic [LEN_W-1:0] LEN1 = 2'h1;
	localparam logic [LEN_W-1:0] LEN2 = 2'h2;
	localparam logic [LEN_W-1:0] LEN3 = 2'h3;
	localparam logic [CYC_W-1:0] CYC1 = 5'h01;
	localparam logic [CYC_W-1:0] CYC2 = 5'h02;
	localparam logic [CYC_W-1:0] CYC3 = 5'h03;
	localparam logic [CYC_W-1:0] CYC4 = 5'h04;
	localparam logic [CYC_W-1:0] CYC5 = 5'h05;
	localparam logic [CYC_W-1:0] XBASE_MUX = 5'h05;
	localparam logic [CYC_W-1:0] XBASE_SEP = 5'h03;
	localparam logic [CYC_W-1:0] CNT_RESET = 5'h00;
	localparam logic [LEN_W-1:0] GOT_RESET = 2'h0;
	typedef enum logic [0:0] {
		CIT_ST_OPC = 1'b0,
		CIT_ST_EXE = 1'b1
	} cit_state_t;
endpackage

// ---- hdl/cit_decode.sv ----
// opcode to byte count and execution cycle count
`timescale 1ns/1ps
`default_nettype none
module cit_decode (
	input wire logic [7:0] opcode,
	output logic [cit_pkg::LEN_W-1:0] len,
	output logic [cit_pkg::CYC_W-1:0] cyc,
	output logic is_movx,
	output logic known
);
	logic [3:0] hi;
	logic [3:0] lo;
	logic alu_row;
	logic logic_row;
	assign hi = opcode[7:4];
	assign lo = opcode[3:0];
	assign alu_row = (hi == 4'h2) || (hi == 4'h3) || (hi == 4'h9) ||
		(hi == 4'h4) || (hi == 4'h5) || (hi == 4'h6);
	assign logic_row = (hi == 4'h4) || (hi == 4'h5) || (hi == 4'h6);
	always_comb begin
		len = cit_pkg::LEN1;
		cyc = cit_pkg::CYC1;
		is_movx = 1'b0;
		known = 1'b1;
		if (alu_row && lo >= 4'h4) begin
			// same column layout for add, addc, subb, and, or, xor
			case (lo)
				4'h4: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC2;
				end
				4'h5: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC3;
				end
				4'h6, 4'h7: begin
					cyc = cit_pkg::CYC3;
				end
				default: begin
					cyc = cit_pkg::CYC2;
				end
			endcase
		end else if (logic_row && lo == 4'h2) begin
			len = cit_pkg::LEN2;
			cyc = cit_pkg::CYC4;
		end else if (logic_row && lo == 4'h3) begin
			len = cit_pkg::LEN3;
			cyc = cit_pkg::CYC4;
		end else begin
			casez (opcode)
				8'b11101???: cyc = cit_pkg::CYC1;
				8'he5, 8'h74: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC2;
				end
				8'b1110011?: cyc = cit_pkg::CYC2;
				8'b11111???: cyc = cit_pkg::CYC2;
				8'b10101???: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC4;
				end
				8'b01111???: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC2;
				end
				8'hf5, 8'b10001???: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC3;
				end
				8'h85: begin
					len = cit_pkg::LEN3;
					cyc = cit_pkg::CYC4;
				end
				8'b1000011?: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC4;
				end
				8'h75: begin
					len = cit_pkg::LEN3;
					cyc = cit_pkg::CYC3;
				end
				8'b1111011?: cyc = cit_pkg::CYC3;
				8'b1010011?, 8'b0111011?: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC3;
				end
				8'h90: begin
					len = cit_pkg::LEN3;
					cyc = cit_pkg::CYC3;
				end
				8'h93, 8'h83: cyc = cit_pkg::CYC4;
				8'he0, 8'b1110001?, 8'hf0, 8'b1111001?: begin
					cyc = cit_pkg::CYC3;
					is_movx = 1'b1;
				end
				8'hc0: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC4;
				end
				8'hd0: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC3;
				end
				8'b11001???: cyc = cit_pkg::CYC3;
				8'hc5: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC4;
				end
				8'b1100011?, 8'b1101011?: cyc = cit_pkg::CYC4;
				8'h04, 8'h14: cyc = cit_pkg::CYC2;
				8'b000?1???: cyc = cit_pkg::CYC3;
				8'h05, 8'h15: begin
					len = cit_pkg::LEN2;
					cyc = cit_pkg::CYC4;
				end
				8'b000?011?: cyc = cit_pkg::CYC4;
				8'ha3: cyc = cit_pkg::CYC1;
				8'ha4, 8'hd4: cyc = cit_pkg::CYC4;
				8'h84: cyc = cit_pkg::CYC5;
				8'he4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4: cyc = cit_pkg::CYC1;
				8'hf4: cyc = cit_pkg::CYC2;
				// unlisted opcodes run as one byte, one cycle and are flagged
				default: known = 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- hdl/cit_xcycles.sv ----
// external auxiliary ram access cycle count from the stretch settings
`timescale 1ns/1ps
`default_nettype none
module cit_xcycles (
	input wire logic ext_addr_interface_select,
	input wire logic [cit_pkg::ALE_W-1:0] ale_stretch,
	input wire logic [cit_pkg::PULSE_W-1:0] rw_pulse_stretch,
	input wire logic strobe_setup_hold_stretch,
	output logic [cit_pkg::CYC_W-1:0] xcyc
);
	logic [cit_pkg::CYC_W-1:0] m2;
	logic [cit_pkg::CYC_W-1:0] n1;
	logic [cit_pkg::CYC_W-1:0] l2;
	assign m2 = {2'h0, ale_stretch, 1'b0};
	assign n1 = {2'h0, rw_pulse_stretch};
	assign l2 = {3'h0, strobe_setup_hold_stretch, 1'b0};
	// widest case is 5 + 6 + 7 + 2 = 20, fits five bits
	always_comb begin
		if (ext_addr_interface_select) begin
			xcyc = cit_pkg::XBASE_SEP + n1 + l2;
		end else begin
			xcyc = cit_pkg::XBASE_MUX + m2 + n1 + l2;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/cit_core.sv ----
// instruction fetch and execution cycle sequencer
// Function
// - register to accumulator move, 1 byte, 1 cycle
// - accumulator loads two cycles, direct/immediate two bytes
// - moves into register: timing by source form
// - moves into direct address: timing by source
// - moves into indirect ram take three cycles
// - data pointer load: three bytes, three cycles
// - both code reads: one byte, four cycles
// - on-chip auxiliary ram moves: one byte, three
// - external ram moves: one byte, 3 to 20
// - push 2 bytes 4 cycles, pop 3 cycles
// - exchange timings: register 3, others 4 cycles
// - add and add-with-carry timing by operand form
// - subtract with borrow timing by operand form
// - logical and timing, direct destination four cycles
// - logical or timing, direct destination four cycles
// - exclusive or timing, direct destination four cycles
// - external cycle count from interface select, stretches
`timescale 1ns/1ps
`default_nettype none
module cit_core (
	input wire logic mclk,
	input wire logic nrst,
	output logic pm_req_r,
	output logic [cit_pkg::PC_W-1:0] pm_addr_r,
	input wire logic pm_ack,
	input wire logic [7:0] pm_data,
	input wire logic movx_external,
	input wire logic ext_addr_interface_select,
	input wire logic [cit_pkg::ALE_W-1:0] ale_stretch,
	input wire logic [cit_pkg::PULSE_W-1:0] rw_pulse_stretch,
	input wire logic strobe_setup_hold_stretch,
	output logic retire_valid_r,
	output logic [7:0] retire_opcode_r,
	output logic [15:0] retire_operand_r,
	output logic [cit_pkg::LEN_W-1:0] retire_len_r,
	output logic [cit_pkg::CYC_W-1:0] retire_cycles_r,
	output logic retire_unknown_r
);
	logic rst_meta_r;
	logic rst_sync_r;
	cit_pkg::cit_state_t state_r;
	logic [7:0] opc_r;
	logic [7:0] opnd1_r;
	logic [7:0] opnd2_r;
	logic [cit_pkg::LEN_W-1:0] len_r;
	logic [cit_pkg::CYC_W-1:0] cyc_r;
	logic unknown_r;
	logic [cit_pkg::LEN_W-1:0] got_r;
	logic [cit_pkg::CYC_W-1:0] cnt_r;
	logic [7:0] dec_opc;
	logic [cit_pkg::LEN_W-1:0] dec_len;
	logic [cit_pkg::CYC_W-1:0] dec_cyc;
	logic dec_movx;
	logic dec_known;
	logic [cit_pkg::CYC_W-1:0] xcyc;
	logic [cit_pkg::CYC_W-1:0] eff_cyc;
	logic take;
	logic [cit_pkg::LEN_W-1:0] got_nxt;
	logic [cit_pkg::CYC_W-1:0] cnt_nxt;
	logic opc_fin;
	logic exe_fin;

	// reset release passes two flops so removal is clean against mclk
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// decode straight off the bus in the opcode cycle so a one cycle
	// instruction can retire without a bubble
	assign dec_opc = (state_r == cit_pkg::CIT_ST_OPC) ? pm_data : opc_r;

	cit_decode u_decode (
		.opcode(dec_opc),
		.len(dec_len),
		.cyc(dec_cyc),
		.is_movx(dec_movx),
		.known(dec_known)
	);

	cit_xcycles u_xcycles (
		.ext_addr_interface_select(ext_addr_interface_select),
		.ale_stretch(ale_stretch),
		.rw_pulse_stretch(rw_pulse_stretch),
		.strobe_setup_hold_stretch(strobe_setup_hold_stretch),
		.xcyc(xcyc)
	);

	// external target replaces the fixed on-chip count
	assign eff_cyc = (dec_movx && movx_external) ? xcyc : dec_cyc;

	assign take = pm_req_r && pm_ack;
	assign got_nxt = take ? got_r + cit_pkg::LEN1 : got_r;
	assign cnt_nxt = cnt_r + cit_pkg::CYC1;
	assign opc_fin = take && (dec_len == cit_pkg::LEN1) &&
		(eff_cyc == cit_pkg::CYC1);
	// commit only once every byte is in and every cycle has elapsed
	assign exe_fin = (cnt_nxt >= cyc_r) && (got_nxt == len_r);

	always_ff @(posedge mclk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			state_r <= cit_pkg::CIT_ST_OPC;
		end else begin
			case (state_r)
				cit_pkg::CIT_ST_OPC: begin
					if (take && !opc_fin) begin
						state_r <= cit_pkg::CIT_ST_EXE;
					end
				end
				cit_pkg::CIT_ST_EXE: begin
					if (exe_fin) begin
						state_r <= cit_pkg::CIT_ST_OPC;
					end
				end
				default: state_r <= cit_pkg::CIT_ST_OPC;
			endcase
		end
	end

	// fetch request and program counter
	always_ff @(posedge mclk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			pm_req_r <= 1'b0;
			pm_addr_r <= cit_pkg::RESET_PC;
		end else begin
			if (take) begin
				pm_addr_r <= pm_addr_r + 16'h0001;
			end
			case (state_r)
				cit_pkg::CIT_ST_OPC: begin
					if (take && !opc_fin) begin
						pm_req_r <= (dec_len != cit_pkg::LEN1);
					end else begin
						pm_req_r <= 1'b1;
					end
				end
				cit_pkg::CIT_ST_EXE: begin
					if (exe_fin) begin
						pm_req_r <= 1'b1;
					end else begin
						pm_req_r <= (got_nxt != len_r);
					end
				end
				default: pm_req_r <= 1'b0;
			endcase
		end
	end

	// instruction latches and counters
	always_ff @(posedge mclk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			opc_r <= 8'h00;
			opnd1_r <= 8'h00;
			opnd2_r <= 8'h00;
			len_r <= cit_pkg::LEN1;
			cyc_r <= cit_pkg::CYC1;
			unknown_r <= 1'b0;
			got_r <= cit_pkg::GOT_RESET;
			cnt_r <= cit_pkg::CNT_RESET;
		end else begin
			if (state_r == cit_pkg::CIT_ST_OPC) begin
				if (take) begin
					opc_r <= pm_data;
					opnd1_r <= 8'h00;
					opnd2_r <= 8'h00;
					len_r <= dec_len;
					cyc_r <= eff_cyc;
					unknown_r <= !dec_known;
					got_r <= cit_pkg::LEN1;
					cnt_r <= cit_pkg::CYC1;
				end
			end else begin
				cnt_r <= cnt_nxt;
				got_r <= got_nxt;
				if (take && got_r == cit_pkg::LEN1) begin
					opnd1_r <= pm_data;
				end
				if (take && got_r == cit_pkg::LEN2) begin
					opnd2_r <= pm_data;
				end
			end
		end
	end

	// retire record; lands one edge after the final execution cycle
	always_ff @(posedge mclk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			retire_valid_r <= 1'b0;
			retire_opcode_r <= 8'h00;
			retire_operand_r <= 16'h0000;
			retire_len_r <= cit_pkg::LEN1;
			retire_cycles_r <= cit_pkg::CNT_RESET;
			retire_unknown_r <= 1'b0;
		end else begin
			retire_valid_r <= 1'b0;
			if (state_r == cit_pkg::CIT_ST_OPC && opc_fin) begin
				retire_valid_r <= 1'b1;
				retire_opcode_r <= pm_data;
				retire_operand_r <= 16'h0000;
				retire_len_r <= cit_pkg::LEN1;
				retire_cycles_r <= cit_pkg::CYC1;
				retire_unknown_r <= !dec_known;
			end else if (state_r == cit_pkg::CIT_ST_EXE && exe_fin) begin
				retire_valid_r <= 1'b1;
				retire_opcode_r <= opc_r;
				retire_operand_r <= {(take && got_r == cit_pkg::LEN1) ?
					pm_data : opnd1_r,
					(take && got_r == cit_pkg::LEN2) ? pm_data : opnd2_r};
				retire_len_r <= len_r;
				// slow program memory can stretch past the table figure
				retire_cycles_r <= cnt_nxt;
				retire_unknown_r <= unknown_r;
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/cit_core_monitor.sv ----
// fetch and retire timing checker for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module cit_core_monitor (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic pm_req_r,
	input wire logic [15:0] pm_addr_r,
	input wire logic pm_ack,
	input wire logic retire_valid_r,
	input wire logic [7:0] retire_opcode_r,
	input wire logic [15:0] retire_operand_r,
	input wire logic [1:0] retire_len_r,
	input wire logic [4:0] retire_cycles_r,
	input wire logic retire_unknown_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_req_after_reset: assert property ($rose(nrst) |->
		!pm_req_r [*3] ##1 pm_req_r) else $error("late first fetch");
	a_addr_step: assert property (pm_req_r && pm_ack |=>
		pm_addr_r == $past(pm_addr_r) + 16'h1) else $error("pc step");
	a_addr_hold: assert property (!(pm_req_r && pm_ack) |=>
		$stable(pm_addr_r)) else $error("pc moved idle");
	a_single_pulse: assert property (
		retire_valid_r && retire_cycles_r != 5'h01 |=>
		!retire_valid_r || retire_cycles_r == 5'h01)
		else $error("retire too long");
	a_reg_move: assert property (
		retire_valid_r && retire_opcode_r == 8'he8 |->
		retire_len_r == 2'h1 && retire_cycles_r == 5'h01)
		else $error("register move timing");
	a_unknown_one: assert property (retire_valid_r && retire_unknown_r |->
		retire_len_r == 2'h1 && retire_cycles_r == 5'h01)
		else $error("unknown timing");
	a_ptr_load: assert property (
		retire_valid_r && retire_opcode_r == 8'h90 |-> retire_len_r == 2'h3)
		else $error("pointer load length");
	a_result_held: assert property (!retire_valid_r |->
		$stable(retire_opcode_r) && $stable(retire_cycles_r))
		else $error("result changed");
	a_short_operand: assert property (
		retire_valid_r && retire_len_r == 2'h1 |-> retire_operand_r == 16'h0)
		else $error("stray operand");
	c_back_to_back: cover property (retire_valid_r ##1 retire_valid_r);
	c_long_ext: cover property (retire_valid_r && retire_cycles_r == 5'h14);
	c_fetch_wait: cover property (pm_req_r && !pm_ack);
endmodule
bind cit_core cit_core_monitor u_mon (.mclk(mclk), .nrst(nrst),
	.pm_req_r(pm_req_r), .pm_addr_r(pm_addr_r), .pm_ack(pm_ack),
	.retire_valid_r(retire_valid_r), .retire_opcode_r(retire_opcode_r),
	.retire_operand_r(retire_operand_r), .retire_len_r(retire_len_r),
	.retire_cycles_r(retire_cycles_r), .retire_unknown_r(retire_unknown_r));
`default_nettype wire

// ---- dv/cit_pm_model.sv ----
// program memory model answering fetches promptly or with waits
`timescale 1ns/1ps
`default_nettype none
module cit_pm_model (
	input wire logic mclk,
	input wire logic slow,
	input wire logic req,
	input wire logic [15:0] addr,
	output logic ack,
	output logic [7:0] data
);
	// zero fill keeps fetches past the program defined
	logic [7:0] mem [0:255] = '{default: 8'h00};
	logic tog_r = 1'b0;
	always @(posedge mclk) tog_r <= ~tog_r;
	// slow mode answers every other cycle so operand bytes arrive late
	assign ack = req && (!slow || tog_r);
	// inverted byte when not answering, so a stale value never passes
	assign data = ack ? mem[addr[7:0]] : ~mem[addr[7:0]];
endmodule
`default_nettype wire

// ---- dv/cit_core_tb_top.sv ----
// self-checking bench for the instruction timing sequencer
`timescale 1ns/1ps
`default_nettype none
module cit_core_tb_top;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic slow = 1'b0;
	logic mx = 1'b0;
	logic sel = 1'b0;
	logic [1:0] ale = 2'h0;
	logic [2:0] pul = 3'h0;
	logic shs = 1'b0;
	logic req, ack, rv, ru;
	logic [15:0] pa, rop;
	logic [7:0] pd, rcode;
	logic [1:0] rlen;
	logic [4:0] rcyc;
	int n_fail = 0;
	int total_checks = 0;
	int wp;
	// {opcode, bytes, cycles}
	logic [15:0] tbl [70] = '{16'he811, 16'he522, 16'he612, 16'h7422,
		16'hf812, 16'ha824, 16'h7822, 16'hf523, 16'h8823, 16'h8534,
		16'h8624, 16'h7533, 16'hf613, 16'ha623, 16'h7623, 16'h9033,
		16'h9314, 16'h8314, 16'he013, 16'he213, 16'hf013, 16'hf213,
		16'hc024, 16'hd023, 16'hc813, 16'hc524, 16'hc614, 16'hd614,
		16'h2812, 16'h2523, 16'h2613, 16'h2422, 16'h3812, 16'h3523,
		16'h3613, 16'h3422, 16'h9812, 16'h9523, 16'h9613, 16'h9422,
		16'h5812, 16'h5523, 16'h5613, 16'h5422, 16'h5224, 16'h5334,
		16'h4812, 16'h4523, 16'h4613, 16'h4422, 16'h4224, 16'h4334,
		16'h6812, 16'h6523, 16'h6613, 16'h6422, 16'h6224, 16'h6334,
		16'h0412, 16'h0813, 16'h0524, 16'h0614, 16'h1412, 16'h1813,
		16'h1524, 16'h1614, 16'ha311, 16'ha414, 16'h8415, 16'hd414};
	always #4 mclk = ~mclk;
	cit_core DUT (.mclk(mclk), .nrst(nrst), .pm_req_r(req), .pm_addr_r(pa),
		.pm_ack(ack), .pm_data(pd), .movx_external(mx),
		.ext_addr_interface_select(sel), .ale_stretch(ale),
		.rw_pulse_stretch(pul), .strobe_setup_hold_stretch(shs),
		.retire_valid_r(rv), .retire_opcode_r(rcode),
		.retire_operand_r(rop), .retire_len_r(rlen),
		.retire_cycles_r(rcyc), .retire_unknown_r(ru));
	cit_pm_model u_pm (.mclk(mclk), .slow(slow), .req(req), .addr(pa),
		.ack(ack), .data(pd));
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic do_reset();
		@(negedge mclk);
		nrst = 1'b0;
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
	endtask
	task automatic put(logic [7:0] op, int len);
		u_pm.mem[wp] = op;
		u_pm.mem[wp+1] = 8'ha5;
		u_pm.mem[wp+2] = 8'h3c;
		wp = wp + len;
	endtask
	task automatic expect_ret(logic [7:0] op, int len, int cyc, bit gap,
			bit lt, bit unk);
		int w;
		logic [15:0] opr;
		w = 0;
		opr = len == 1 ? 16'h0 : (len == 2 ? 16'ha500 : 16'ha53c);
		do begin
			@(posedge mclk);
			#1;
			w++;
		end while (rv !== 1'b1 && w < 300);
		if (w >= 300) begin
			n_fail++;
			summarize();
		end
		check(16'(rcode), 16'(op));
		check(16'(rlen), 16'(len));
		check(rop, opr);
		check(16'(ru), 16'(unk));
		if (lt)
			check(16'(rcyc >= cyc), 16'h1);
		else
			check(16'(rcyc), 16'(cyc));
		if (gap && !lt)
			check(16'(w), 16'(cyc));
	endtask
	// late bytes only stretch the count, so exact figures need zero wait
	task automatic run_tbl(int a, int b, bit lt);
		@(negedge mclk);
		slow = lt;
		wp = 0;
		for (int i = a; i <= b; i++)
			put(tbl[i][15:8], tbl[i][7:4]);
		do_reset();
		for (int i = a; i <= b; i++)
			expect_ret(tbl[i][15:8], tbl[i][7:4], tbl[i][3:0], i > a, lt,
				1'b0);
	endtask
	task automatic t_unknown();
		@(negedge mclk);
		slow = 1'b0;
		wp = 0;
		put(8'ha5, 1);
		put(8'he8, 1);
		do_reset();
		expect_ret(8'ha5, 1, 1, 1'b0, 1'b0, 1'b1);
		expect_ret(8'he8, 1, 1, 1'b1, 1'b0, 1'b0);
	endtask
	task automatic t_ext();
		logic [6:0] cf [5] = '{7'h00, 7'h7f, 7'h3f, 7'h40, 7'h14};
		logic [7:0] ops [5] = '{8'he0, 8'he2, 8'hf0, 8'hf2, 8'he0};
		int e;
		for (int i = 0; i < 5; i++) begin
			@(negedge mclk);
			mx = 1'b1;
			{sel, ale, pul, shs} = cf[i];
			e = sel ? 3 + pul + 2 * shs : 5 + 2 * ale + pul + 2 * shs;
			wp = 0;
			put(ops[i], 1);
			do_reset();
			expect_ret(ops[i], 1, e, 1'b0, 1'b0, 1'b0);
		end
	endtask
	initial begin
		run_tbl(0, 17, 1'b0);
		run_tbl(18, 27, 1'b0);
		run_tbl(28, 39, 1'b0);
		run_tbl(40, 57, 1'b0);
		run_tbl(58, 69, 1'b0);
		t_ext();
		run_tbl(5, 11, 1'b1);
		t_unknown();
		summarize();
	end
endmodule
`default_nettype wire
